/* verilog/ccl_master_end.sv */
// Cached master end: tracks one line through CleanUnique, CleanShared and
// CleanInvalid. Assumes the interconnect end on the same clock via ccl_link_if.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RQ1] Clean requests on AR, completion on R
// [RQ2] CleanUnique answer must be unique and clean
// [RQ3] Shared lines become unique on CleanUnique
// [RQ4] Invalid and unique lines keep state on CleanUnique
// [RQ5] Invalid line allocated only by full store
// [RQ6] Full store after CleanUnique leaves unique-dirty
// [RQ7] Snoops held off until the store finishes
// [RQ8] Snoop filter counts line allocated at completion
// [RQ9] Unallocated line: full store, write-back or evict
// [RQ10] CleanUnique returns no data, only ownership
// [RQ11] Interconnect cleans and removes other copies
// [RQ12] CleanUnique may carry the exclusive flag
// [RQ13] CleanShared allowed in any region
// [RQ14] Dirty line written clean before CleanShared
// [RQ15] Local writes allowed while CleanShared outstanding
// [RQ16] CleanShared answer never passes dirty
// [RQ17] CleanShared response sets shared or unique clean
// [RQ18] Dirty after CleanShared only from local write
// [RQ19] CleanInvalid allowed in any region
// [RQ20] Dirty line written back, invalidated, then CleanInvalid
// [RQ21] CleanInvalid answers 00, line stays invalid
// [RQ22] Five line states; bit 3 shared, 2 dirty
module ccl_master_end (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Link
  ccl_link_if.master_mp link,
  // Maintenance request
  input wire logic req_valid_i,
  input wire ccl_pkg::ccl_txn_t req_kind_i,
  input wire logic req_shareable_i,
  input wire logic req_excl_i,
  output logic req_ready_o,
  output logic done_o,
  output logic resp_err_o,
  // Local store
  input wire logic store_valid_i,
  input wire logic store_full_i,
  input wire logic store_none_i,
  // Line preload, standing in for the read transactions
  input wire logic fill_valid_i,
  input wire ccl_pkg::ccl_line_t fill_state_i,
  // Status
  output ccl_pkg::ccl_line_t line_state_o,
  output logic snoop_held_o
);
  import ccl_pkg::*;

  typedef enum logic [2:0] {
    st_idle    = 3'h0,
    st_pre_wr  = 3'h1,
    st_ar      = 3'h2,
    st_r       = 3'h3,
    st_store   = 3'h4,
    st_post_wr = 3'h5
  } ccl_mst_st_t;

  ccl_mst_st_t state_ff, nxt_state;
  ccl_line_t line_ff, nxt_line;
  ccl_line_t resp_line;
  ccl_txn_t kind_ff;
  ccl_wr_t aw_kind_ff, nxt_aw_kind;
  logic resp_legal, shareable_ff, excl_ff, wrote_ff;
  logic ar_valid_ff, r_ready_ff, ac_ready_ff, aw_valid_ff;
  logic req_ready_ff, done_ff, err_ff, held_ff;
  logic req_take, ar_fire, r_fire, ac_fire, aw_fire;

  assign req_take = (state_ff == st_idle) && req_ready_ff && req_valid_i && !fill_valid_i;
  assign ar_fire = ar_valid_ff && link.ar_ready; // RQ1
  assign r_fire = r_ready_ff && link.r_valid; // RQ1
  assign ac_fire = ac_ready_ff && link.ac_valid;
  assign aw_fire = aw_valid_ff && link.aw_ready;

  ccl_line_next u_next (
    .start_i(line_ff),
    .kind_i(kind_ff),
    .wrote_i(wrote_ff),
    .resp_i(link.r_resp),
    .next_o(resp_line),
    .legal_o(resp_legal)
  );

  always_comb
  begin
    nxt_state = state_ff;
    nxt_line = line_ff;
    nxt_aw_kind = aw_kind_ff;
    case (state_ff)
      st_idle:
      begin
        if (fill_valid_i)
          nxt_line = fill_state_i;
        else if (req_take)
        begin
          if (line_is_dirty(line_ff) && (req_kind_i != txn_clean_unique))
          begin
            // Clean the line first; invalidation needs a full write-back
            nxt_state = st_pre_wr; // RQ14 RQ20
            nxt_aw_kind = (req_kind_i == txn_clean_invalid) ? wr_write_back : wr_write_clean;
          end
          else
          begin
            if (req_kind_i == txn_clean_invalid)
              nxt_line = line_invalid; // RQ20
            nxt_state = st_ar;
          end
        end
        else if (store_valid_i && line_is_unique(line_ff))
          nxt_line = line_unique_dirty;
      end
      st_pre_wr:
      begin
        if (aw_fire)
        begin
          nxt_line = (kind_ff == txn_clean_invalid) ? line_invalid : line_cleaned(line_ff); // RQ20
          nxt_state = st_ar;
        end
      end
      st_ar:
        if (ar_fire)
          nxt_state = st_r;
      st_r:
      begin
        if (r_fire)
        begin
          nxt_line = resp_line; // RQ3 RQ4 RQ17 RQ21
          nxt_state = (kind_ff == txn_clean_unique) ? st_store : st_idle;
        end
      end
      st_store:
      begin
        if (store_valid_i && ((line_ff != line_invalid) || store_full_i))
        begin
          nxt_line = line_unique_dirty; // RQ5 RQ6
          nxt_state = st_idle;
        end
        else if (store_valid_i || (store_none_i && (line_ff == line_invalid)))
        begin
          // Unallocated line: a partial store goes straight out, no store evicts
          nxt_aw_kind = store_valid_i ? wr_write_back : wr_evict; // RQ9
          nxt_state = st_post_wr;
        end
        else if (store_none_i)
          nxt_state = st_idle;
      end
      st_post_wr:
        if (aw_fire)
          nxt_state = st_idle;
      default:
        nxt_state = st_idle;
    endcase
    // A snoop taken in this cycle removes the line
    if (ac_fire)
      nxt_line = line_invalid;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_ff <= st_idle;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      line_ff <= LINE_RESET;
    else
      line_ff <= nxt_line;
  end

  // Request attributes, held for the whole sequence
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      kind_ff <= txn_clean_unique;
      shareable_ff <= 1'b0;
      excl_ff <= 1'b0;
    end
    else if (req_take)
    begin
      kind_ff <= req_kind_i;
      // CleanUnique only makes sense for shareable memory
      shareable_ff <= req_shareable_i || (req_kind_i == txn_clean_unique); // RQ13 RQ19
      excl_ff <= req_excl_i && (req_kind_i == txn_clean_unique); // RQ12
    end
  end

  // Local write while CleanShared is outstanding
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wrote_ff <= 1'b0;
    else if (state_ff == st_idle)
      wrote_ff <= 1'b0;
    else if ((state_ff == st_ar || state_ff == st_r) && (kind_ff == txn_clean_shared) &&
             store_valid_i && line_is_unique(line_ff))
      wrote_ff <= 1'b1; // RQ15 RQ18
  end

  // Channel handshakes; valids drop on the edge that completes them
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ar_valid_ff <= 1'b0;
      r_ready_ff <= 1'b0;
      aw_valid_ff <= 1'b0;
      aw_kind_ff <= wr_write_back;
    end
    else
    begin
      ar_valid_ff <= (nxt_state == st_ar); // RQ1
      r_ready_ff <= (nxt_state == st_r); // RQ1
      aw_valid_ff <= (nxt_state == st_pre_wr) || (nxt_state == st_post_wr);
      aw_kind_ff <= nxt_aw_kind;
    end
  end

  // Snoops wait while the store that follows CleanUnique is pending
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ac_ready_ff <= 1'b0;
      held_ff <= 1'b0;
    end
    else
    begin
      ac_ready_ff <= !ac_fire && ((nxt_state == st_idle) || (nxt_state == st_ar) ||
                     (nxt_state == st_r)); // RQ7
      held_ff <= (nxt_state == st_store); // RQ7
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      req_ready_ff <= 1'b0;
      done_ff <= 1'b0;
      err_ff <= 1'b0;
    end
    else
    begin
      req_ready_ff <= (nxt_state == st_idle);
      done_ff <= (state_ff != st_idle) && (nxt_state == st_idle);
      // Only a single response beat is expected; no data comes back
      err_ff <= r_fire && (!resp_legal || !link.r_last); // RQ10
    end
  end

  assign link.ar_valid = ar_valid_ff;
  assign link.ar_kind = kind_ff;
  assign link.ar_shareable = shareable_ff;
  assign link.ar_excl = excl_ff;
  assign link.r_ready = r_ready_ff;
  assign link.ac_ready = ac_ready_ff;
  assign link.aw_valid = aw_valid_ff;
  assign link.aw_kind = aw_kind_ff;
  assign req_ready_o = req_ready_ff;
  assign done_o = done_ff;
  assign resp_err_o = err_ff;
  assign line_state_o = line_ff;
  assign snoop_held_o = held_ff;
endmodule
`default_nettype wire

/* include/ccl_pkg.sv */
// Shared types and constants for the clean-transaction line state link.
// Assumes one clock and one asynchronous active-low reset on both ends.
`default_nettype none
package ccl_pkg;

  // Line state, one of five values
  typedef enum logic [2:0] {
    line_invalid      = 3'h0,
    line_unique_clean = 3'h1,
    line_unique_dirty = 3'h2,
    line_shared_clean = 3'h3,
    line_shared_dirty = 3'h4
  } ccl_line_t;

  // Clean transactions carried on the read address channel
  typedef enum logic [1:0] {
    txn_clean_unique  = 2'h0,
    txn_clean_shared  = 2'h1,
    txn_clean_invalid = 2'h2
  } ccl_txn_t;

  // Follow-up requests carried on the write address channel
  typedef enum logic [1:0] {
    wr_write_back  = 2'h0,
    wr_write_clean = 2'h1,
    wr_evict       = 2'h2
  } ccl_wr_t;

  localparam int unsigned RESP_W = 4;
  localparam int unsigned RESP_IS_SHARED_BIT = 3;
  localparam int unsigned RESP_PASS_DIRTY_BIT = 2;
  localparam logic [RESP_W-1:0] RESP_UNIQUE_CLEAN = 4'h0;
  localparam ccl_line_t LINE_RESET = line_invalid;
  localparam int unsigned ICN_RESP_LAT = 2;
  localparam int unsigned LAT_CNT_W = 8;

  function automatic logic line_is_dirty(input ccl_line_t s);
    return (s == line_unique_dirty) || (s == line_shared_dirty);
  endfunction

  function automatic logic line_is_unique(input ccl_line_t s);
    return (s == line_unique_clean) || (s == line_unique_dirty);
  endfunction

  // State left once a write-back or write-clean has made the line clean
  function automatic ccl_line_t line_cleaned(input ccl_line_t s);
    case (s)
      line_unique_dirty: return line_unique_clean;
      line_shared_dirty: return line_shared_clean;
      default: return s;
    endcase
  endfunction

endpackage
`default_nettype wire

/* include/ccl_link_if.sv */
// Link between the cached master and the coherent interconnect.
// Single-beat responses; the testbench instantiates it and joins both ends.
`timescale 1ns/1ps
`default_nettype none
interface ccl_link_if (
  input wire logic mclk_i,
  input wire logic rst_n_i
);
  logic ar_valid;
  logic ar_ready;
  ccl_pkg::ccl_txn_t ar_kind;
  logic ar_shareable;
  logic ar_excl;
  logic r_valid;
  logic r_ready;
  logic [ccl_pkg::RESP_W-1:0] r_resp;
  logic r_last;
  logic ac_valid;
  logic ac_ready;
  logic aw_valid;
  logic aw_ready;
  ccl_pkg::ccl_wr_t aw_kind;

  modport master_mp (
    output ar_valid, ar_kind, ar_shareable, ar_excl, r_ready, ac_ready,
    output aw_valid, aw_kind,
    input ar_ready, r_valid, r_resp, r_last, ac_valid, aw_ready
  );

  modport icn_mp (
    input ar_valid, ar_kind, ar_shareable, ar_excl, r_ready, ac_ready,
    input aw_valid, aw_kind,
    output ar_ready, r_valid, r_resp, r_last, ac_valid, aw_ready
  );
endinterface
`default_nettype wire

/* verilog/ccl_line_next.sv */
// Line state after a clean-transaction response, and whether the response is legal.
// Purely combinational; the master samples it on the response handshake.
`timescale 1ns/1ps
`default_nettype none
module ccl_line_next (
  // Current line and transaction
  input wire ccl_pkg::ccl_line_t start_i,
  input wire ccl_pkg::ccl_txn_t kind_i,
  input wire logic wrote_i,
  // Response
  input wire logic [ccl_pkg::RESP_W-1:0] resp_i,
  output ccl_pkg::ccl_line_t next_o,
  output logic legal_o
);
  import ccl_pkg::*;

  logic is_shared;
  logic pass_dirty;

  assign is_shared = resp_i[RESP_IS_SHARED_BIT]; // RQ22
  assign pass_dirty = resp_i[RESP_PASS_DIRTY_BIT]; // RQ22

  always_comb
  begin
    next_o = start_i;
    legal_o = 1'b1;
    case (kind_i)
      txn_clean_unique:
      begin
        legal_o = !is_shared && !pass_dirty; // RQ2
        // Invalid and unique lines keep their state
        if (start_i == line_shared_clean)
          next_o = line_unique_clean; // RQ3
        else if (start_i == line_shared_dirty)
          next_o = line_unique_dirty; // RQ3
      end
      txn_clean_shared:
      begin
        legal_o = !pass_dirty; // RQ16
        if (start_i == line_unique_clean)
        begin
          // A local write during the transaction is what makes it dirty
          if (wrote_i)
            next_o = is_shared ? line_shared_dirty : line_unique_dirty; // RQ18
          else
            next_o = is_shared ? line_shared_clean : line_unique_clean; // RQ17
        end
        else if (start_i == line_shared_clean)
          next_o = is_shared ? line_shared_clean : line_unique_clean; // RQ17
      end
      txn_clean_invalid:
      begin
        legal_o = !is_shared && !pass_dirty; // RQ21
        next_o = line_invalid; // RQ21
      end
      default:
        legal_o = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

/* verilog/ccl_icn_end.sv */
// Coherent interconnect end: answers clean transactions, issues snoops on
// request and keeps a one-line snoop-filter allocation view.
`timescale 1ns/1ps
`default_nettype none
module ccl_icn_end #(
  parameter int unsigned RESP_LAT = ccl_pkg::ICN_RESP_LAT,
  parameter bit HAS_SNOOP_FILTER = 1'b1
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Link
  ccl_link_if.icn_mp link,
  // Response control
  input wire logic shared_i,
  input wire logic snoop_req_i,
  // Status
  output logic clean_others_o,
  output logic alloc_o,
  output logic wr_seen_o,
  output ccl_pkg::ccl_wr_t wr_kind_o
);
  import ccl_pkg::*;

  if (RESP_LAT < 1 || RESP_LAT > 255)
  begin : g_bad_lat
    $error("RESP_LAT must lie between 1 and 255");
  end

  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_wait = 2'h1,
    st_resp = 2'h2
  } ccl_icn_st_t;

  ccl_icn_st_t state_ff;
  ccl_txn_t kind_ff;
  ccl_wr_t wr_kind_ff;
  logic [LAT_CNT_W-1:0] cnt_ff;
  logic [RESP_W-1:0] resp_ff;
  logic ar_ready_ff;
  logic r_valid_ff;
  logic ac_valid_ff;
  logic aw_ready_ff;
  logic others_ff;
  logic alloc_ff;
  logic wr_seen_ff;
  logic ar_fire;
  logic r_fire;
  logic aw_fire;

  assign ar_fire = link.ar_valid && ar_ready_ff;
  assign r_fire = r_valid_ff && link.r_ready;
  assign aw_fire = link.aw_valid && aw_ready_ff;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= st_idle;
      kind_ff <= txn_clean_unique;
      cnt_ff <= '0;
      resp_ff <= RESP_UNIQUE_CLEAN;
      ar_ready_ff <= 1'b0;
      r_valid_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        st_idle:
        begin
          ar_ready_ff <= !ar_fire;
          if (ar_fire)
          begin
            kind_ff <= link.ar_kind;
            cnt_ff <= LAT_CNT_W'(RESP_LAT - 1);
            state_ff <= st_wait;
          end
        end
        st_wait:
        begin
          if (cnt_ff == '0)
          begin
            // Only CleanShared may report sharing; nothing passes dirty
            if (kind_ff == txn_clean_shared)
              resp_ff <= shared_i ? 4'h8 : RESP_UNIQUE_CLEAN; // RQ16
            else
              resp_ff <= RESP_UNIQUE_CLEAN; // RQ2 RQ21
            r_valid_ff <= 1'b1;
            state_ff <= st_resp;
          end
          else
            cnt_ff <= cnt_ff - 1'b1;
        end
        st_resp:
        begin
          if (r_fire)
          begin
            r_valid_ff <= 1'b0;
            ar_ready_ff <= 1'b1;
            state_ff <= st_idle;
          end
        end
        default:
          state_ff <= st_idle;
      endcase
    end
  end

  // Other caches are cleaned and emptied when CleanUnique is taken
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      others_ff <= 1'b0;
    else
      others_ff <= ar_fire && (link.ar_kind == txn_clean_unique); // RQ11
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ac_valid_ff <= 1'b0;
    else if (ac_valid_ff && link.ac_ready)
      ac_valid_ff <= 1'b0;
    else if (snoop_req_i)
      ac_valid_ff <= 1'b1;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_ready_ff <= 1'b0;
      wr_seen_ff <= 1'b0;
      wr_kind_ff <= wr_write_back;
    end
    else
    begin
      aw_ready_ff <= !aw_fire;
      wr_seen_ff <= aw_fire;
      if (aw_fire)
        wr_kind_ff <= link.aw_kind;
    end
  end

  // Allocation view: set wins over a clear in the same cycle
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      alloc_ff <= 1'b0;
    else if (HAS_SNOOP_FILTER && r_fire && (kind_ff == txn_clean_unique))
      alloc_ff <= 1'b1; // RQ8
    else if ((aw_fire && (link.aw_kind != wr_write_clean)) ||
             (ac_valid_ff && link.ac_ready))
      alloc_ff <= 1'b0; // RQ9
  end

  assign link.ar_ready = ar_ready_ff;
  assign link.r_valid = r_valid_ff;
  assign link.r_resp = resp_ff;
  assign link.r_last = r_valid_ff;
  assign link.ac_valid = ac_valid_ff;
  assign link.aw_ready = aw_ready_ff;
  assign clean_others_o = others_ff;
  assign alloc_o = alloc_ff;
  assign wr_seen_o = wr_seen_ff;
  assign wr_kind_o = wr_kind_ff;
endmodule
`default_nettype wire

/* test/ccl_link_props.sv */
// Protocol checker for the clean-transaction line state link.
// Takes the link signals as plain inputs; placed beside the interface.
`timescale 1ns/1ps
`default_nettype none
module ccl_link_props
  import ccl_pkg::*;
#(
  parameter int unsigned RESP_LAT = ICN_RESP_LAT
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Request and response
  input wire logic ar_valid,
  input wire logic ar_ready,
  input wire ccl_pkg::ccl_txn_t ar_kind,
  input wire logic ar_excl,
  input wire logic r_valid,
  input wire logic r_ready,
  input wire logic [ccl_pkg::RESP_W-1:0] r_resp,
  input wire logic r_last,
  // Snoop and follow-up write
  input wire logic ac_valid,
  input wire logic ac_ready,
  input wire logic aw_valid,
  input wire logic aw_ready
);
  localparam int LAT_D = RESP_LAT + 1;
  ccl_txn_t kind_ff;

  // Kind of the request in flight, so responses can be judged after AR drops
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      kind_ff <= txn_clean_unique;
    else if (ar_valid && ar_ready)
      kind_ff <= ar_kind;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_ar_take;
    ar_valid && ar_ready;
  endsequence
  sequence s_cu_done;
    r_valid && r_ready && kind_ff == txn_clean_unique;
  endsequence

  property p_ar_hold;
    ar_valid && !ar_ready |=> ar_valid && $stable(ar_kind);
  endproperty
  property p_r_lat;
    s_ar_take |-> ##LAT_D r_valid;
  endproperty
  property p_cu_resp;
    r_valid && kind_ff == txn_clean_unique |-> r_resp == 4'h0;
  endproperty
  property p_cs_resp;
    r_valid && kind_ff == txn_clean_shared |-> r_resp[RESP_PASS_DIRTY_BIT] == 1'b0;
  endproperty
  property p_ci_resp;
    r_valid && kind_ff == txn_clean_invalid |-> r_resp == 4'h0;
  endproperty
  property p_r_single;
    r_valid && r_ready |-> r_last ##1 !r_valid;
  endproperty
  property p_excl;
    ar_valid && ar_excl |-> ar_kind == txn_clean_unique;
  endproperty
  property p_snoop_hold;
    s_cu_done |=> !ac_ready;
  endproperty
  property p_aw_hold;
    aw_valid && !aw_ready |=> aw_valid;
  endproperty

  a_ar_hold: assert property (p_ar_hold) else $error("request dropped early");
  a_r_lat: assert property (p_r_lat) else $error("response late");
  a_cu_resp: assert property (p_cu_resp) else $error("unique answer not 00");
  a_cs_resp: assert property (p_cs_resp) else $error("shared answer passes dirty");
  a_ci_resp: assert property (p_ci_resp) else $error("invalid answer not 00");
  a_r_single: assert property (p_r_single) else $error("response not single beat");
  a_excl: assert property (p_excl) else $error("exclusive flag on wrong kind");
  a_snoop_hold: assert property (p_snoop_hold) else $error("snoop not held off");
  a_aw_hold: assert property (p_aw_hold) else $error("write request dropped");
endmodule
`default_nettype wire

/* test/coherent_clean_txn_line_state_test.sv */
// Self-checking bench for the clean-transaction line state link.
// Joins both ends through ccl_link_if on one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module coherent_clean_txn_line_state_test;
  import ccl_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  ccl_txn_t req_kind_i = txn_clean_unique;
  logic req_shareable_i = 1'b0;
  logic req_excl_i = 1'b0;
  logic store_valid_i = 1'b0;
  logic store_full_i = 1'b0;
  logic store_none_i = 1'b0;
  logic fill_valid_i = 1'b0;
  ccl_line_t fill_state_i = line_invalid;
  logic shared_i = 1'b0;
  logic snoop_req_i = 1'b0;
  logic req_ready_o, done_o, resp_err_o, snoop_held_o, clean_others_o, alloc_o, wr_seen_o;
  ccl_line_t line_state_o;
  ccl_line_t win_st;
  ccl_wr_t wr_kind_o;
  ccl_wr_t wr_k;
  logic seen_clean, seen_err, seen_hold, seen_wr;
  int fails = 0;
  int tests_run = 0;

  always #5 mclk_i = ~mclk_i;

  ccl_link_if ccl_link_if_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i));

  ccl_master_end ccl_master_end_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(ccl_link_if_i),
    .req_valid_i(req_valid_i), .req_kind_i(req_kind_i), .req_shareable_i(req_shareable_i),
    .req_excl_i(req_excl_i), .req_ready_o(req_ready_o), .done_o(done_o),
    .resp_err_o(resp_err_o), .store_valid_i(store_valid_i), .store_full_i(store_full_i),
    .store_none_i(store_none_i), .fill_valid_i(fill_valid_i), .fill_state_i(fill_state_i),
    .line_state_o(line_state_o), .snoop_held_o(snoop_held_o));

  ccl_icn_end #(.RESP_LAT(2), .HAS_SNOOP_FILTER(1'b1)) ccl_icn_end_i (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .link(ccl_link_if_i), .shared_i(shared_i), .snoop_req_i(snoop_req_i),
    .clean_others_o(clean_others_o), .alloc_o(alloc_o), .wr_seen_o(wr_seen_o),
    .wr_kind_o(wr_kind_o));

  ccl_link_props #(.RESP_LAT(2)) ccl_link_props_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .ar_valid(ccl_link_if_i.ar_valid), .ar_ready(ccl_link_if_i.ar_ready),
    .ar_kind(ccl_link_if_i.ar_kind), .ar_excl(ccl_link_if_i.ar_excl),
    .r_valid(ccl_link_if_i.r_valid), .r_ready(ccl_link_if_i.r_ready),
    .r_resp(ccl_link_if_i.r_resp), .r_last(ccl_link_if_i.r_last),
    .ac_valid(ccl_link_if_i.ac_valid), .ac_ready(ccl_link_if_i.ac_ready),
    .aw_valid(ccl_link_if_i.aw_valid), .aw_ready(ccl_link_if_i.aw_ready));

  task automatic end_sim;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic fill(input ccl_line_t s, input logic shr);
    @(posedge mclk_i);
    fill_valid_i <= 1'b1;
    fill_state_i <= s;
    shared_i <= shr;
    @(posedge mclk_i);
    fill_valid_i <= 1'b0;
  endtask

  // Mode 0 stores in the window after completion, 1 stores mid-flight, 2 never
  task automatic run_req(input ccl_txn_t k, input logic ex, input logic sh, input int mode,
    input logic sfull, input logic snone, input logic snp);
    int dly;
    logic armed;
    dly = (mode == 1) ? 1 : -1;
    armed = (mode == 0);
    {seen_clean, seen_err, seen_hold, seen_wr} = 4'h0;
    win_st = line_invalid;
    @(posedge mclk_i);
    req_valid_i <= 1'b1;
    req_kind_i <= k;
    req_excl_i <= ex;
    req_shareable_i <= sh;
    @(posedge mclk_i);
    req_valid_i <= 1'b0;
    req_excl_i <= 1'b0;
    for (int i = 0; i < 100; i++)
    begin
      @(posedge mclk_i);
      store_valid_i <= (dly == 0) && !snone;
      store_full_i <= (dly == 0) && sfull;
      store_none_i <= (dly == 0) && snone;
      snoop_req_i <= snp && (dly == 1);
      if (dly >= 0)
        dly--;
      #1;
      seen_clean |= clean_others_o;
      seen_err |= resp_err_o;
      seen_hold |= ccl_link_if_i.ac_valid && !ccl_link_if_i.ac_ready && snoop_held_o;
      if (wr_seen_o)
      begin
        seen_wr = 1'b1;
        wr_k = wr_kind_o;
      end
      if (armed && snoop_held_o)
      begin
        armed = 1'b0;
        win_st = line_state_o;
        dly = snp ? 1 : 0;
      end
      if (done_o)
        break;
    end
    `CHK("done", 1'b1, done_o)
    `CHK("resp_err", 1'b0, seen_err)
    `CHK("req_ready", 1'b1, req_ready_o)
    `CHK("ar_shareable", sh || (k == txn_clean_unique), ccl_link_if_i.ar_shareable)
    `CHK("ar_excl", ex && (k == txn_clean_unique), ccl_link_if_i.ar_excl)
  endtask

  task automatic t_cu_states;
    ccl_line_t st[4] = '{line_shared_clean, line_shared_dirty, line_unique_clean,
      line_unique_dirty};
    ccl_line_t ex[4] = '{line_unique_clean, line_unique_dirty, line_unique_clean,
      line_unique_dirty};
    for (int n = 0; n < 4; n++)
    begin
      fill(st[n], 1'b0);
      run_req(txn_clean_unique, 1'b0, 1'b1, 0, 1'b0, 1'b1, 1'b0);
      `CHK("cu_window", ex[n], win_st)
      `CHK("cu_end", ex[n], line_state_o)
      `CHK("cu_clean_others", 1'b1, seen_clean)
      `CHK("cu_alloc", 1'b1, alloc_o)
    end
  endtask

  task automatic t_cu_snoop;
    fill(line_shared_clean, 1'b0);
    run_req(txn_clean_unique, 1'b0, 1'b1, 0, 1'b0, 1'b0, 1'b1);
    `CHK("snoop_held", 1'b1, seen_hold)
    repeat (3) @(posedge mclk_i);
    #1;
    `CHK("snoop_after_store", line_invalid, line_state_o)
    `CHK("snoop_alloc", 1'b0, alloc_o)
  endtask

  task automatic t_cu_invalid;
    logic full[3] = '{1'b1, 1'b0, 1'b0};
    logic none[3] = '{1'b0, 1'b0, 1'b1};
    ccl_line_t ex[3] = '{line_unique_dirty, line_invalid, line_invalid};
    ccl_wr_t wk[3] = '{wr_write_back, wr_write_back, wr_evict};
    for (int n = 0; n < 3; n++)
    begin
      fill(line_invalid, 1'b0);
      run_req(txn_clean_unique, full[n], 1'b0, 0, full[n], none[n], 1'b0);
      repeat (2) @(posedge mclk_i);
      #1;
      `CHK("inv_window", line_invalid, win_st)
      `CHK("inv_end", ex[n], line_state_o)
      `CHK("inv_alloc", full[n], alloc_o)
      `CHK("inv_wr_seen", !full[n], seen_wr)
      if (!full[n])
        `CHK("inv_wr_kind", wk[n], wr_k)
    end
  endtask

  task automatic t_cu_full_store;
    fill(line_shared_clean, 1'b0);
    run_req(txn_clean_unique, 1'b0, 1'b1, 0, 1'b1, 1'b0, 1'b0);
    `CHK("full_store_end", line_unique_dirty, line_state_o)
  endtask

  task automatic t_cs_table;
    ccl_line_t st[5] = '{line_shared_clean, line_shared_clean, line_unique_clean,
      line_invalid, line_invalid};
    logic shr[5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    ccl_line_t ex[5] = '{line_unique_clean, line_shared_clean, line_unique_clean,
      line_invalid, line_invalid};
    for (int n = 0; n < 5; n++)
    begin
      fill(st[n], shr[n]);
      run_req(txn_clean_shared, 1'b1, n[0], 2, 1'b0, 1'b0, 1'b0);
      `CHK("cs_end", ex[n], line_state_o)
      `CHK("cs_no_wr", 1'b0, seen_wr)
    end
  endtask

  task automatic t_cs_local_write;
    ccl_line_t ex[2] = '{line_unique_dirty, line_shared_dirty};
    for (int n = 0; n < 2; n++)
    begin
      fill(line_unique_clean, n[0]);
      run_req(txn_clean_shared, 1'b0, 1'b1, 1, 1'b0, 1'b0, 1'b0);
      `CHK("cs_write_end", ex[n], line_state_o)
    end
  endtask

  task automatic t_dirty_first;
    fill(line_unique_dirty, 1'b0);
    run_req(txn_clean_shared, 1'b0, 1'b1, 2, 1'b0, 1'b0, 1'b0);
    `CHK("cs_dirty_wr", 1'b1, seen_wr)
    `CHK("cs_dirty_kind", wr_write_clean, wr_k)
    `CHK("cs_dirty_end", line_unique_clean, line_state_o)
    fill(line_shared_dirty, 1'b0);
    run_req(txn_clean_invalid, 1'b0, 1'b1, 2, 1'b0, 1'b0, 1'b0);
    `CHK("ci_dirty_kind", wr_write_back, wr_k)
    `CHK("ci_dirty_end", line_invalid, line_state_o)
    fill(line_shared_clean, 1'b0);
    run_req(txn_clean_invalid, 1'b0, 1'b0, 2, 1'b0, 1'b0, 1'b0);
    `CHK("ci_clean_wr", 1'b0, seen_wr)
    `CHK("ci_clean_end", line_invalid, line_state_o)
  endtask

  // A full run takes well under 2000 cycles
  initial
  begin
    #50us;
    fails++;
    end_sim;
  end

  initial
  begin
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    t_cu_states;
    t_cu_snoop;
    t_cu_invalid;
    t_cu_full_store;
    t_cs_table;
    t_cs_local_write;
    t_dirty_first;
    end_sim;
  end
endmodule
`default_nettype wire
